//--- verilog/sleep_mode_power_controller.sv
// sleep mode entry, clock gating, deep sleep and wake sequencing
// Contract
// [R01] power-down or power-save with radio asleep enters deep sleep
// [R02] software must not sleep deep while the radio is still waking
// [R03] deep sleep turns off digital and analog regulators and power chain
// [R04] sram held in retention throughout deep sleep; code retains it only while the power chain is off
// [R05] deep wake restores chain first, then normal wake continues
// [R06] software disables the adc before deep sleep
// [R07] sleep only when arm bit set and sleep instruction runs
// [R08] select 000 gives idle, 001 gives adc quiet mode
// [R09] interrupt wake holds cpu four cycles past start-up time
// [R10] wake keeps register file and sram contents
// [R11] reset during sleep wakes and restarts at reset vector
// [R12] idle gates only cpu and flash clocks
// [R13] adc quiet mode gates io, cpu and flash clocks
// [R14] adc enabled at idle or quiet entry starts a conversion
// [R15] adc quiet mode accepts its listed wake events
// [R16] deeper modes: upper external lines wake only level-triggered
// [R17] async domain and timer2 wake only when timer2 runs async; idle keeps both regardless of timer2 mode
// [R18] software may set comparator off bit in idle
// [R19] select 010 gives power-down, 011 gives power-save
// [R20] 110 and 111 give standby modes, six cycle wake
// [R21] with arm bit clear sleep instruction does nothing
`include "sleep_ctrl_map.svh"
module sleep_mode_power_controller #(
  parameter int startup_cycles = `STARTUP_CYCLES_DEFAULT
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic sleep_arm_bit_in,
  input wire logic [2:0] sleep_select_field_in,
  input wire logic sleep_instr_in,
  input wire logic radio_asleep_in,
  input wire logic adc_enable_in,
  input wire logic timer2_async_in,
  input wire logic high_irq_level_in,
  input wire logic [10:0] wake_raw_in,
  input wire logic reset_raw_in,
  output logic cpu_clock_domain_out,
  output logic flash_clock_domain_out,
  output logic io_clock_domain_out,
  output logic adc_clock_domain_out,
  output logic async_clock_domain_out,
  output logic main_osc_on_out,
  output logic timer_osc_on_out,
  output logic digital_supply_rail_out,
  output logic analog_supply_rail_out,
  output logic power_chain_on_out,
  output logic sram_retain_out,
  output logic adc_start_out,
  output logic cpu_halted_out,
  output logic run_irq_out,
  output logic reset_vector_out,
  output logic deep_sleep_out,
  output logic [2:0] sleep_mode_out
);
  import sleep_ctrl_pkg::*;

  sleep_sync_if sync_bus();
  sleep_wake_sync u_sync (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .wake_raw_in(wake_raw_in),
    .reset_raw_in(reset_raw_in),
    .sync(sync_bus.producer)
  );

  sleep_state_type state, next_state;
  logic [2:0] mode, next_mode;
  logic deep, next_deep;
  logic [15:0] count, next_count;
  logic chain_on, next_chain_on;
  logic [5:0] gate, next_gate; // cpu,flash,io,adc,async,main osc
  logic timer_osc, next_timer_osc;
  logic adc_start, next_adc_start;
  logic run_irq, next_run_irq;
  logic rst_vec, next_rst_vec;
  logic by_reset, next_by_reset;
  logic retain, next_retain;
  logic halted, next_halted;
  wake_vec_type allowed;
  logic wake_hit;
  logic sel_legal;

  // allowed wake sources per mode
  always_comb begin
    allowed = 11'h000;
    unique case (mode)
      `SEL_IDLE: allowed = 11'h7ff; // [R12]
      `SEL_ADC_QUIET: allowed = 11'h6fe; // [R15]
      `SEL_POWER_DOWN, `SEL_STANDBY: allowed = 11'h78e; // [R19] [R20]
      `SEL_POWER_SAVE, `SEL_EXT_STANDBY: allowed = 11'h79e;
      default: allowed = 11'h000;
    endcase
    // upper external lines only as level interrupts outside idle
    if (mode != `SEL_IDLE && !high_irq_level_in) begin
      allowed[2] = 1'b0; // [R16]
    end
    // timer2 wake needs async operation in every mode except idle
    if (mode != `SEL_IDLE && !timer2_async_in) begin
      allowed[4] = 1'b0; // [R17]
    end
    wake_hit = |(sync_bus.wake & allowed);
  end

  always_comb begin
    sel_legal = sleep_select_field_in inside {`SEL_IDLE, `SEL_ADC_QUIET,
      `SEL_POWER_DOWN, `SEL_POWER_SAVE, `SEL_STANDBY, `SEL_EXT_STANDBY};
  end

  // sequencer
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_deep = deep;
    next_count = count;
    next_chain_on = chain_on;
    next_adc_start = 1'b0;
    next_run_irq = 1'b0;
    next_rst_vec = 1'b0;
    next_by_reset = by_reset;
    if (sync_bus.reset_req && state != st_run) begin
      // reset wake still waits for the power chain, then restarts
      next_by_reset = 1'b1; // [R11]
    end
    unique case (state)
      st_run: begin
        // reserved select codes never enter a mode
        if (sleep_instr_in && sleep_arm_bit_in && sel_legal) begin // [R07] [R21]
          next_state = st_sleep;
          next_mode = sleep_select_field_in;
          next_by_reset = 1'b0;
          next_deep = radio_asleep_in &&
            (sleep_select_field_in == `SEL_POWER_DOWN ||
             sleep_select_field_in == `SEL_POWER_SAVE); // [R01]
          if (adc_enable_in && (sleep_select_field_in == `SEL_IDLE ||
              sleep_select_field_in == `SEL_ADC_QUIET)) begin
            next_adc_start = 1'b1; // [R14]
          end
        end
      end
      st_sleep: begin
        if (deep) begin
          next_chain_on = 1'b0; // [R03]
        end
        if (wake_hit || sync_bus.reset_req) begin
          next_state = deep ? st_chain_up : st_startup;
          next_count = (mode == `SEL_STANDBY || mode == `SEL_EXT_STANDBY) ?
            16'(`STANDBY_WAKE_CYCLES) : 16'(startup_cycles); // [R20]
        end
      end
      st_chain_up: begin
        next_chain_on = 1'b1; // [R05]
        if (chain_on) begin
          next_state = st_startup;
          next_deep = 1'b0;
        end
      end
      st_startup: begin
        if (count <= 16'h0001) begin
          next_state = st_halt;
          next_count = 16'(`WAKE_HALT_CYCLES); // [R09]
        end else begin
          next_count = count - 16'h0001;
        end
      end
      st_halt: begin
        if (count <= 16'h0001) begin
          next_state = st_run;
          next_count = 16'h0000;
          next_run_irq = !by_reset;
          next_rst_vec = by_reset; // [R11]
          next_by_reset = 1'b0;
        end else begin
          next_count = count - 16'h0001;
        end
      end
    endcase
  end

  // clock gating per mode, ones mean running
  always_comb begin
    next_gate = 6'h3f;
    next_timer_osc = 1'b1;
    if (next_state == st_sleep) begin
      unique case (next_mode)
        `SEL_IDLE: next_gate = 6'h0f; // [R12] [R08]
        `SEL_ADC_QUIET: next_gate = 6'h07; // [R13] [R08]
        `SEL_STANDBY, `SEL_EXT_STANDBY: next_gate = 6'h01; // [R20]
        default: next_gate = 6'h00;
      endcase
      if (next_mode != `SEL_IDLE && next_mode != `SEL_POWER_DOWN &&
          next_mode != `SEL_STANDBY) begin
        next_gate[1] = timer2_async_in; // [R17]
      end else if (next_mode != `SEL_IDLE) begin
        next_gate[1] = 1'b0;
      end
      next_timer_osc = next_gate[1];
    end else if (next_state != st_run) begin
      // waking: everything but the cpu runs again
      next_gate = 6'h1f;
    end
    next_halted = !next_gate[5];
    next_retain = next_deep && !next_chain_on; // [R04]
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      state <= st_run;
      mode <= `SEL_IDLE;
      deep <= 1'b0;
      count <= 16'h0000;
      chain_on <= 1'b1;
      gate <= 6'h3f;
      timer_osc <= 1'b1;
      adc_start <= 1'b0;
      run_irq <= 1'b0;
      rst_vec <= 1'b0;
      by_reset <= 1'b0;
      retain <= 1'b0;
      halted <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      deep <= next_deep;
      count <= next_count;
      chain_on <= next_chain_on;
      gate <= next_gate;
      timer_osc <= next_timer_osc;
      adc_start <= next_adc_start;
      run_irq <= next_run_irq;
      rst_vec <= next_rst_vec;
      by_reset <= next_by_reset;
      retain <= next_retain;
      halted <= next_halted;
    end
  end

  // register file and sram are never written here, only retained
  assign cpu_clock_domain_out = gate[5]; // [R10]
  assign flash_clock_domain_out = gate[4];
  assign io_clock_domain_out = gate[3];
  assign adc_clock_domain_out = gate[2];
  assign async_clock_domain_out = gate[1];
  assign main_osc_on_out = gate[0];
  assign timer_osc_on_out = timer_osc;
  assign digital_supply_rail_out = chain_on; // [R03]
  assign analog_supply_rail_out = chain_on;
  assign power_chain_on_out = chain_on;
  assign sram_retain_out = retain; // [R04]
  assign adc_start_out = adc_start;
  assign cpu_halted_out = halted;
  assign run_irq_out = run_irq;
  assign reset_vector_out = rst_vec;
  assign deep_sleep_out = deep;
  assign sleep_mode_out = mode;

  property p_arm;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (state == st_run && sleep_instr_in && !sleep_arm_bit_in) |=> state == st_run;
  endproperty
  a_arm: assert property (p_arm) else $error("sleep entered unarmed"); // [R21]
  property p_deep;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (state == st_run && sleep_instr_in && sleep_arm_bit_in && radio_asleep_in &&
       sleep_select_field_in == `SEL_POWER_DOWN) |=> deep ##1 !chain_on;
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep not entered"); // [R01]
  property p_idle;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (state == st_sleep && mode == `SEL_IDLE) |-> gate[5:2] == 4'h3;
  endproperty
  a_idle: assert property (p_idle) else $error("idle gating wrong"); // [R12]
  property p_quiet;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (state == st_sleep && mode == `SEL_ADC_QUIET) |-> gate[5:2] == 4'h1;
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet gating wrong"); // [R13]
  property p_ret;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      !chain_on |-> sram_retain_out;
  endproperty
  a_ret: assert property (p_ret) else $error("sram not retained"); // [R04]
  property p_halt;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (state == st_startup && $past(state) == st_startup && count == 16'h0001)
      |=> state == st_halt [*4] ##1 state == st_run;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not four cycles"); // [R09]
  property p_chain;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      state == st_startup |-> chain_on;
  endproperty
  a_chain: assert property (p_chain) else $error("startup before chain"); // [R05]
  property p_adc;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (state == st_run && sleep_instr_in && sleep_arm_bit_in && adc_enable_in &&
       sleep_select_field_in == `SEL_IDLE) |=> adc_start;
  endproperty
  a_adc: assert property (p_adc) else $error("no adc start"); // [R14]
  property p_rst;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (state == st_halt && by_reset && count == 16'h0001) |=> rst_vec && !run_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset wake wrong vector"); // [R11]
  c_deep: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    state == st_chain_up);
  c_idle: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    run_irq && mode == `SEL_IDLE);
  c_sb: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    run_irq && mode == `SEL_STANDBY);
endmodule

//--- verilog/sleep_ctrl_map.svh
// constants for the sleep mode power controller
`ifndef SLEEP_CTRL_MAP_SVH
`define SLEEP_CTRL_MAP_SVH
`define SEL_IDLE 3'h0
`define SEL_ADC_QUIET 3'h1
`define SEL_POWER_DOWN 3'h2
`define SEL_POWER_SAVE 3'h3
`define SEL_STANDBY 3'h6
`define SEL_EXT_STANDBY 3'h7
`define WAKE_HALT_CYCLES 4'h4
`define STANDBY_WAKE_CYCLES 4'h6
`define STARTUP_CYCLES_DEFAULT 16
`define WAKE_IDLE_IDX 0
`define WAKE_ADC_IDX 1
`define WAKE_PD_IDX 2
`define WAKE_PS_IDX 3
`define WAKE_SB_IDX 4
`define WAKE_ESB_IDX 5
`endif

//--- verilog/sleep_ctrl_pkg.sv
// types for the sleep mode power controller
package sleep_ctrl_pkg;
  typedef enum logic [2:0] {
    st_run, st_sleep, st_chain_up, st_startup, st_halt
  } sleep_state_type;
  // wake sources: 0 irq_other,1 ext_low,2 ext_high_level,3 twi match,
  // 4 timer2,5 store ready,6 adc done,7 wdt,8 io other,9 symbol cnt,10 radio
  typedef logic [10:0] wake_vec_type;
endpackage

//--- verilog/sleep_sync_if.sv
// synchronised wake request lines shared between the synchroniser and the core
interface sleep_sync_if;
  logic [10:0] wake;
  logic reset_req;
  modport producer(output wake, output reset_req);
  modport consumer(input wake, input reset_req);
endinterface

//--- verilog/sleep_wake_sync.sv
// two-stage synchroniser for the asynchronous wake and reset inputs
module sleep_wake_sync (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [10:0] wake_raw_in,
  input wire logic reset_raw_in,
  sleep_sync_if.producer sync
);
  logic [11:0] stage1;
  logic [11:0] stage2;
  logic [11:0] next_stage1;
  logic [11:0] next_stage2;
  always_comb begin
    next_stage1 = {reset_raw_in, wake_raw_in};
    next_stage2 = stage1;
  end
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      stage1 <= 12'h000;
      stage2 <= 12'h000;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end
  assign sync.wake = stage2[10:0];
  assign sync.reset_req = stage2[11];
endmodule

//--- tb/radio_far_model.sv
// behavioural radio transceiver: sleep state and awake interrupt
module radio_far_model #(
  parameter int wake_len = 12
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic sleep_cmd_in,
  output logic radio_asleep_out,
  output logic radio_awake_irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int count;
  // leaves sleep at once, but is only usable after its settle time
  always_ff @(posedge ref_clk_in) begin
    radio_awake_irq_out <= 1'b0;
    if (!reset_n_in) begin
      radio_asleep_out <= 1'b0;
      count <= 0;
    end else if (sleep_cmd_in) begin
      radio_asleep_out <= 1'b1;
      count <= 0;
    end else if (radio_asleep_out) begin
      radio_asleep_out <= 1'b0;
      count <= wake_len;
    end else if (count == 1) begin
      count <= 0;
      radio_awake_irq_out <= 1'b1;
    end else if (count > 1) begin
      count <= count - 1;
    end
  end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the sleep mode power controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sleep_ctrl_pkg::*;
  typedef struct packed {
    logic arm;
    logic [2:0] sel;
    logic adc;
    logic t2;
    logic [5:0] exp;
    logic start;
    logic [3:0] cyc;
  } row_type;
  localparam int startup = 8;
  logic ref_clk_in = 0, reset_n_in = 0, arm = 0, instr = 0, radio_cmd = 0;
  logic adc_en = 0, t2_async = 0, hi_level = 0, rst_raw = 0, seen;
  logic [2:0] sel = 3'h0;
  wake_vec_type wake = '0;
  logic cpu_clk, flash_clk, io_clk, adc_clk, async_clk, main_osc, timer_osc, dig_rail;
  logic ana_rail, chain, retain, adc_start, halted, run_irq, rst_vec, deep;
  logic radio_asleep, radio_irq;
  logic [2:0] mode;
  int err_total = 0, checked = 0, n;
  // domain bits: cpu, flash, io, adc, async, deep
  row_type rows[9] = '{
    '{1, 3'h0, 1, 0, 6'h0e, 1, 4'h8}, '{1, 3'h1, 1, 1, 6'h06, 1, 4'h8},
    '{1, 3'h2, 1, 1, 6'h00, 0, 4'h8}, '{1, 3'h3, 0, 0, 6'h00, 0, 4'h8},
    '{1, 3'h3, 0, 1, 6'h02, 0, 4'h8}, '{1, 3'h6, 0, 1, 6'h00, 0, 4'h6},
    '{1, 3'h7, 0, 1, 6'h02, 0, 4'h6}, '{0, 3'h0, 1, 0, 6'h3e, 0, 4'h0},
    '{1, 3'h4, 1, 0, 6'h3e, 0, 4'h0}};

  sleep_mode_power_controller #(.startup_cycles(startup)) i_dut (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .sleep_arm_bit_in(arm),
    .sleep_select_field_in(sel), .sleep_instr_in(instr), .radio_asleep_in(radio_asleep),
    .adc_enable_in(adc_en), .timer2_async_in(t2_async), .high_irq_level_in(hi_level),
    .wake_raw_in(wake), .reset_raw_in(rst_raw), .cpu_clock_domain_out(cpu_clk),
    .flash_clock_domain_out(flash_clk), .io_clock_domain_out(io_clk),
    .adc_clock_domain_out(adc_clk), .async_clock_domain_out(async_clk),
    .main_osc_on_out(main_osc), .timer_osc_on_out(timer_osc),
    .digital_supply_rail_out(dig_rail), .analog_supply_rail_out(ana_rail),
    .power_chain_on_out(chain), .sram_retain_out(retain), .adc_start_out(adc_start),
    .cpu_halted_out(halted), .run_irq_out(run_irq), .reset_vector_out(rst_vec),
    .deep_sleep_out(deep), .sleep_mode_out(mode));

  radio_far_model i_radio (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .sleep_cmd_in(radio_cmd),
    .radio_asleep_out(radio_asleep), .radio_awake_irq_out(radio_irq));

  initial begin
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait, sampled mid-cycle so one-cycle pulses are caught
  task automatic wait_hi(ref logic sig, output int cnt);
    cnt = 0;
    while (sig !== 1'b1 && cnt < 300) begin
      @(negedge ref_clk_in);
      cnt++;
    end
  endtask

  task automatic sleep_now();
    @(posedge ref_clk_in);
    instr <= 1'b1;
    @(posedge ref_clk_in);
    instr <= 1'b0;
  endtask

  task automatic print_verdict();
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    @(negedge ref_clk_in);
    check({cpu_clk, flash_clk, io_clk, adc_clk, dig_rail, ana_rail, chain}, 16'h7f);
    check({deep, retain, mode}, 16'h0);
    check({main_osc, timer_osc, halted}, 3'b110);
    foreach (rows[i]) begin
      @(posedge ref_clk_in);
      arm <= rows[i].arm;
      sel <= rows[i].sel;
      adc_en <= rows[i].adc;
      t2_async <= rows[i].t2;
      sleep_now();
      seen = 1'b0;
      repeat (3) begin
        @(negedge ref_clk_in);
        seen = seen | adc_start;
      end
      check({cpu_clk, flash_clk, io_clk, adc_clk, async_clk, deep}, rows[i].exp);
      check(seen, rows[i].start);
      if (rows[i].exp[5] === 1'b0) begin
        check(mode, rows[i].sel);
        @(posedge ref_clk_in);
        wake[7] <= 1'b1;
        wait_hi(run_irq, n);
        check(n >= rows[i].cyc + 4 && n < 300, 1'b1);
        @(posedge ref_clk_in);
        wake[7] <= 1'b0;
        @(negedge ref_clk_in);
        check({cpu_clk, halted}, 2'b10);
      end
    end
    // deep sleep: radio asleep, converter off first
    @(posedge ref_clk_in);
    radio_cmd <= 1'b1;
    adc_en <= 1'b0;
    sel <= 3'h2;
    arm <= 1'b1;
    wait_hi(radio_asleep, n);
    sleep_now();
    repeat (4) @(negedge ref_clk_in);
    check({deep, dig_rail, ana_rail, chain, retain}, 5'b10001);
    check({main_osc, timer_osc, halted}, 3'b001);
    @(posedge ref_clk_in);
    wake[7] <= 1'b1;
    wait_hi(dig_rail, n);
    check(cpu_clk, 1'b0);
    wait_hi(run_irq, n);
    check({deep, dig_rail, ana_rail, chain, retain, n < 300}, 6'b011101);
    @(posedge ref_clk_in);
    wake[7] <= 1'b0;
    radio_cmd <= 1'b0;
    wait_hi(radio_irq, n);
    check(n < 300, 1'b1);
    // upper external lines need level mode outside idle
    sleep_now();
    @(posedge ref_clk_in);
    wake[2] <= 1'b1;
    repeat (30) @(negedge ref_clk_in);
    check(cpu_clk, 1'b0);
    @(posedge ref_clk_in);
    hi_level <= 1'b1;
    wait_hi(run_irq, n);
    check(n < 300, 1'b1);
    @(posedge ref_clk_in);
    wake[2] <= 1'b0;
    sleep_now();
    @(posedge ref_clk_in);
    rst_raw <= 1'b1;
    wait_hi(rst_vec, n);
    check(n < 300, 1'b1);
    @(posedge ref_clk_in);
    rst_raw <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    print_verdict();
  end
endmodule
